// ===== inc/dpcr_defines.vh
// constants for the demodulator profile and coefficient memories
// assumes inclusion by bare name from core/ modules
// Behaviour
// - profile memory holds 32 entries of 64 bits each.
// - vector fields: pointer 35:28, decimation 27:22, frequency 21:6.
// - gain compensation in bits 4:2; bit 5 reserved; bits 1:0 ignored.
// - filter reads blocks from pointer times 8, for M blocks.
// - active profile chosen by index field bits 15:11 of select register.
// - new settings take effect only on pin sync pulse or manual trigger bit.
// - profile vector is one 64-bit serial write, msb first.
// - profile write pointer increments after each vector write.
// - addresses with upper nibble 0xc are accepted by both subchips.
// - coefficient memory holds 256 blocks of 112 bits.
// - coefficient block is one 112-bit serial write, msb first.
// - coefficient k sits in bits 14k+13 down to 14k.
// - stored coefficients are 14-bit two's complement values.
// - symmetric fir of 16M taps; only 8M coefficients stored.
// - block j position I holds coefficient M*(1+I)-(1+j).
// - manual start enable makes manual start address override pointer.
// - pointer, decimation, frequency and gain each have a manual value.
// - memories are not cleared by reset.
// - coefficient write pointer increments after each block write.
`ifndef DPCR_DEFINES_VH
`define DPCR_DEFINES_VH
`define DPCR_ADDR_W 8
`define DPCR_DATA_W 16
`define DPCR_BCAST_NIB 4'hc
`define DPCR_SUB_BIT 7
`define DPCR_REG_CTRL 6'h00
`define DPCR_REG_CPTR 6'h06
`define DPCR_REG_CBLK 6'h07
`define DPCR_REG_PPTR 6'h08
`define DPCR_REG_PVEC 6'h09
`define DPCR_REG_PSEL 6'h0e
`define DPCR_REG_MDEC 6'h1f
`define DPCR_REG_MFEN 6'h20
`define DPCR_REG_MFRQ 6'h21
`define DPCR_REG_GFRC 6'h1d
`define DPCR_TRIG_BIT 2
`define DPCR_PROF_N 32
`define DPCR_PROF_AW 5
`define DPCR_PROF_W 64
`define DPCR_COEF_N 256
`define DPCR_COEF_AW 8
`define DPCR_COEF_W 112
`define DPCR_TAP_W 14
`define DPCR_TAPS 8
`define DPCR_PTR_HI 35
`define DPCR_PTR_LO 28
`define DPCR_DEC_HI 27
`define DPCR_DEC_LO 22
`define DPCR_FRQ_HI 21
`define DPCR_FRQ_LO 6
`define DPCR_GAIN_HI 4
`define DPCR_GAIN_LO 2
`define DPCR_IDX_HI 15
`define DPCR_IDX_LO 11
`define DPCR_MCS_EN 15
`define DPCR_MCS_HI 14
`define DPCR_MCS_LO 7
`define DPCR_MDEC_EN 6
`define DPCR_MDEC_HI 5
`define DPCR_MDEC_LO 0
`define DPCR_GFRC_EN 7
`define DPCR_GFRC_HI 6
`define DPCR_GFRC_LO 4
`define DPCR_BLK_SHIFT 3
`define DPCR_CNT_W 7
`define DPCR_SCID_HI 7
`define DPCR_SCID_LO 6
`define DPCR_BCAST_SCID 2'h3
`define DPCR_LEN_REG 8'h18
`define DPCR_LEN_PVEC 8'h48
`define DPCR_LEN_CBLK 8'h78
`endif

// ===== core/dpcr_sync2.v
// two-stage synchroniser for one level from outside the clock domain
// assumes i_sys_clk is the consuming domain
`timescale 1ns/1ps
`default_nettype none
module dpcr_sync2 (
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst_b,
   // level in and out
   input wire i_async,
   output reg o_sync
);
   reg meta;
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== core/dpcr_profile_coeff_ram.v
// serial-port profile and coefficient memories with trigger activation
// assumes serial pins and sync pin are asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "dpcr_defines.vh"
module dpcr_profile_coeff_ram (
   // clock and reset
   input wire i_sys_clk,
   input wire i_rst_b,
   // serial port pins
   input wire i_serial_select_n,
   input wire i_serial_clk,
   input wire i_serial_din,
   input wire i_digital_space_select,
   output reg o_serial_dout,
   output reg o_serial_dout_oe,
   // trigger pin and sampling clock presence
   input wire i_tx_sync,
   input wire i_adc_clk_ok,
   // working parameters
   output reg [7:0] o_coef_ptr,
   output reg [5:0] o_dec_factor,
   output reg [15:0] o_dwn_freq,
   output reg [2:0] o_gain_comp,
   output reg [7:0] o_coef_base,
   output reg o_params_valid,
   // coefficient read port for the filter
   input wire [7:0] i_coef_rd_off,
   output reg [111:0] o_coef_block
);
   wire sen_n;
   wire sclk;
   wire sdin;
   wire dsel;
   wire txs;
   wire clk_ok;
   dpcr_sync2 u_sen (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_async(i_serial_select_n), .o_sync(sen_n));
   dpcr_sync2 u_sclk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_async(i_serial_clk), .o_sync(sclk));
   dpcr_sync2 u_sdin (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_async(i_serial_din), .o_sync(sdin));
   dpcr_sync2 u_dsel (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_async(i_digital_space_select), .o_sync(dsel));
   dpcr_sync2 u_txs (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_async(i_tx_sync), .o_sync(txs));
   dpcr_sync2 u_clk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_async(i_adc_clk_ok), .o_sync(clk_ok));

   // memories: plain flops without reset so contents survive it
   reg [`DPCR_PROF_W-1:0] prof_mem [0:`DPCR_PROF_N-1];
   reg [`DPCR_COEF_W-1:0] coef_mem [0:`DPCR_COEF_N-1];

   // control registers
   reg [`DPCR_COEF_AW-1:0] coef_wptr;
   reg [`DPCR_PROF_AW-1:0] prof_wptr;
   reg [15:0] psel;
   reg [15:0] mdec;
   reg mfreq_en;
   reg [15:0] mfreq;
   reg [15:0] gfrc;
   reg man_trig;

   // serial shifter
   reg sclk_d;
   reg [`DPCR_COEF_W+`DPCR_ADDR_W-1:0] shreg;
   reg [`DPCR_CNT_W:0] bitcnt;
   reg [`DPCR_ADDR_W-1:0] addr;
   reg txs_d;
   wire sclk_rise;
   wire frame;
   wire [5:0] reg_idx;
   wire bcast;
   wire [15:0] word16;
   wire [`DPCR_PROF_W-1:0] pvec;
   wire [`DPCR_COEF_W-1:0] cblk;
   wire trig;
   reg [`DPCR_CNT_W:0] need;
   reg [15:0] rd_word;

   assign sclk_rise = sclk & ~sclk_d;
   // writes land only in demodulator space with the sampling clock up
   assign frame = ~sen_n & ~dsel & clk_ok;
   assign reg_idx = addr[5:0];
   // both subchip id bits set means broadcast, for every register index
   assign bcast = (addr[`DPCR_SCID_HI:`DPCR_SCID_LO] == `DPCR_BCAST_SCID);
   assign word16 = shreg[15:0];
   assign pvec = shreg[`DPCR_PROF_W-1:0];
   assign cblk = shreg[`DPCR_COEF_W-1:0];
   assign trig = (txs & ~txs_d) | man_trig;

   // expected word length in bits, address byte included, for the current address
   always @* begin
      need = `DPCR_LEN_REG;
      if (reg_idx == `DPCR_REG_PVEC)
         need = `DPCR_LEN_PVEC;
      else if (reg_idx == `DPCR_REG_CBLK)
         need = `DPCR_LEN_CBLK;
   end

   always @* begin
      case (reg_idx)
         `DPCR_REG_CPTR: rd_word = {8'h00, coef_wptr};
         `DPCR_REG_PPTR: rd_word = {11'h000, prof_wptr};
         `DPCR_REG_PSEL: rd_word = psel;
         `DPCR_REG_MDEC: rd_word = mdec;
         `DPCR_REG_MFEN: rd_word = {15'h0000, mfreq_en};
         `DPCR_REG_MFRQ: rd_word = mfreq;
         `DPCR_REG_GFRC: rd_word = gfrc;
         default: rd_word = 16'h0000;
      endcase
   end

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sclk_d <= 1'b0;
         shreg <= {(`DPCR_COEF_W+`DPCR_ADDR_W){1'b0}};
         bitcnt <= {(`DPCR_CNT_W+1){1'b0}};
         addr <= 8'h00;
         coef_wptr <= 8'h00;
         prof_wptr <= 5'h00;
         psel <= 16'h0000;
         mdec <= 16'h0000;
         mfreq_en <= 1'b0;
         mfreq <= 16'h0000;
         gfrc <= 16'h0000;
         man_trig <= 1'b0;
         o_serial_dout <= 1'b0;
         o_serial_dout_oe <= 1'b0;
      end else begin
         sclk_d <= sclk;
         man_trig <= 1'b0;
         o_serial_dout_oe <= frame;
         if (!frame) begin
            bitcnt <= {(`DPCR_CNT_W+1){1'b0}};
         end else if (sclk_rise) begin
            shreg <= {shreg[`DPCR_COEF_W+`DPCR_ADDR_W-2:0], sdin};
            bitcnt <= bitcnt + 1'b1;
            if (bitcnt == `DPCR_ADDR_W - 1)
               addr <= {shreg[`DPCR_ADDR_W-2:0], sdin};
            if (bitcnt >= `DPCR_ADDR_W)
               o_serial_dout <= rd_word[`DPCR_DATA_W-1];
            if (bitcnt == need - 1'b1) begin
               bitcnt <= {(`DPCR_CNT_W+1){1'b0}};
               case (bcast ? reg_idx : 6'h3f)
                  // trigger bit 2 sits two places behind the newest bit, which is still on sdin
                  `DPCR_REG_CTRL:
                     man_trig <= shreg[`DPCR_TRIG_BIT - 1];
                  `DPCR_REG_CPTR:
                     coef_wptr <= {shreg[6:0], sdin};
                  `DPCR_REG_PPTR:
                     prof_wptr <= {shreg[3:0], sdin};
                  `DPCR_REG_CBLK:
                     coef_wptr <= coef_wptr + 1'b1;
                  `DPCR_REG_PVEC:
                     prof_wptr <= prof_wptr + 1'b1;
                  `DPCR_REG_PSEL: psel <= {shreg[14:0], sdin};
                  `DPCR_REG_MDEC: mdec <= {shreg[14:0], sdin};
                  `DPCR_REG_MFEN: mfreq_en <= sdin;
                  `DPCR_REG_MFRQ: mfreq <= {shreg[14:0], sdin};
                  `DPCR_REG_GFRC: gfrc <= {shreg[14:0], sdin};
                  default: ;
               endcase
            end
         end
      end
   end

   // memory writes: no reset, contents survive device reset
   always @(posedge i_sys_clk) begin
      if (frame && sclk_rise && bcast && (bitcnt == need - 1'b1)) begin
         if (reg_idx == `DPCR_REG_PVEC)
            prof_mem[prof_wptr] <= {pvec[`DPCR_PROF_W-2:0], sdin};
         if (reg_idx == `DPCR_REG_CBLK)
            coef_mem[coef_wptr] <= {cblk[`DPCR_COEF_W-2:0], sdin};
      end
   end

   // active profile and selected fields
   wire [`DPCR_PROF_W-1:0] sel_vec;
   assign sel_vec = prof_mem[psel[`DPCR_IDX_HI:`DPCR_IDX_LO]];

   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         txs_d <= 1'b0;
         o_coef_ptr <= 8'h00;
         o_dec_factor <= 6'h00;
         o_dwn_freq <= 16'h0000;
         o_gain_comp <= 3'h0;
         o_coef_base <= 8'h00;
         o_params_valid <= 1'b0;
      end else begin
         txs_d <= txs;
         // datapath holds its settings until a trigger arrives
         if (trig) begin
            o_params_valid <= 1'b1;
            o_coef_ptr <= mdec[`DPCR_MCS_EN] ?
               mdec[`DPCR_MCS_HI:`DPCR_MCS_LO] :
               sel_vec[`DPCR_PTR_HI:`DPCR_PTR_LO];
            o_coef_base <= (mdec[`DPCR_MCS_EN] ?
               mdec[`DPCR_MCS_HI:`DPCR_MCS_LO] :
               sel_vec[`DPCR_PTR_HI:`DPCR_PTR_LO])
               << `DPCR_BLK_SHIFT;
            o_dec_factor <= mdec[`DPCR_MDEC_EN] ?
               mdec[`DPCR_MDEC_HI:`DPCR_MDEC_LO] :
               sel_vec[`DPCR_DEC_HI:`DPCR_DEC_LO];
            o_dwn_freq <= mfreq_en ? mfreq :
               sel_vec[`DPCR_FRQ_HI:`DPCR_FRQ_LO];
            // bits 5 and 1:0 of the vector are never looked at
            o_gain_comp <= gfrc[`DPCR_GFRC_EN] ?
               gfrc[`DPCR_GFRC_HI:`DPCR_GFRC_LO] :
               sel_vec[`DPCR_GAIN_HI:`DPCR_GAIN_LO];
         end
      end
   end

   // filter fetches blocks base+j for j below M; layout per block is
   // coefficient k at 14k+13:14k, signed, one polyphase phase each
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         o_coef_block <= {`DPCR_COEF_W{1'b0}};
      else
         o_coef_block <= coef_mem[o_coef_base + i_coef_rd_off];
   end
endmodule
`default_nettype wire

// ===== tb/dpcr_spi_host.sv
// serial host model that loads the profile and coefficient memories
// assumes the device samples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module dpcr_spi_host (
   // serial pins toward the device
   output logic o_select_n,
   output logic o_sclk,
   output logic o_din,
   output logic o_dsel
);
   initial begin
      o_select_n = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
      o_dsel = 1'b1;
   end
   // odd offset keeps serial edges clear of the system clock edges
   task open_frame;
      #1.3;
      o_select_n = 1'b0;
      o_dsel = 1'b0;
      #62.5;
   endtask
   // released data line shows the inverse, never a held value
   task close_frame;
      #62.5;
      o_select_n = 1'b1;
      o_dsel = 1'b1;
      o_din = ~o_din;
   endtask
   // address byte then n data bits, msb first; clock idles low
   task send(input logic [7:0] a, input logic [111:0] d, input int n);
      logic [119:0] u;
      u = {a, d << (112 - n)};
      for (int i = 0; i < 8 + n; i++) begin
         o_din = u[119 - i];
         #62.5 o_sclk = 1'b1;
         #62.5 o_sclk = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/dpcr_chk.sv
// assertions on the profile memory block ports
// assumes it is bound into the top design module
`timescale 1ns/1ps
`default_nettype none
module dpcr_chk (
   // clock, reset and pins
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_serial_select_n,
   input wire logic i_tx_sync,
   input wire logic i_digital_space_select,
   input wire logic i_adc_clk_ok,
   // outputs watched
   input wire logic o_serial_dout_oe,
   input wire logic [7:0] o_coef_ptr,
   input wire logic [5:0] o_dec_factor,
   input wire logic [15:0] o_dwn_freq,
   input wire logic [2:0] o_gain_comp,
   input wire logic [7:0] o_coef_base,
   input wire logic o_params_valid
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // cycles since a frame or sync pulse; saturates so it never wraps
   logic [3:0] quiet;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) quiet <= 4'h0;
      else if (!i_serial_select_n || i_tx_sync) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end
   sequence s_sync_edge;
      !i_tx_sync ##1 i_tx_sync;
   endsequence
   sequence s_idle;
      i_serial_select_n [*6];
   endsequence
   // the port is gated off while the sampling clock is down
   sequence s_frame;
      (!i_serial_select_n && !i_digital_space_select && i_adc_clk_ok) [*6];
   endsequence
   a_base_ptr: assert property (o_coef_base == {o_coef_ptr[4:0], 3'h0})
      else $error("base is not pointer times eight");
   a_hold_quiet: assert property (quiet >= 4'h8 |->
      $stable({o_coef_ptr, o_dec_factor, o_dwn_freq, o_gain_comp}))
      else $error("parameters moved without a trigger");
   a_sync_latch: assert property (s_sync_edge |->
      ##[1:8] o_params_valid)
      else $error("sync pulse did not latch parameters");
   a_release_clear: assert property ($rose(i_rst_b) |->
      !o_params_valid && o_coef_ptr == 8'h00)
      else $error("parameters not clear after reset");
   a_valid_stays: assert property (o_params_valid |=> o_params_valid)
      else $error("valid dropped");
   a_valid_cause: assert property ($rose(o_params_valid) |-> quiet < 4'h8)
      else $error("valid rose with no trigger");
   a_oe_idle: assert property (s_idle |-> !o_serial_dout_oe)
      else $error("output enable outside frame");
   a_oe_frame: assert property (s_frame |-> o_serial_dout_oe)
      else $error("output enable low in frame");
endmodule
bind dpcr_profile_coeff_ram dpcr_chk i_chk (.i_sys_clk(i_sys_clk),
   .i_rst_b(i_rst_b), .i_serial_select_n(i_serial_select_n),
   .i_tx_sync(i_tx_sync),
   .i_digital_space_select(i_digital_space_select),
   .i_adc_clk_ok(i_adc_clk_ok), .o_serial_dout_oe(o_serial_dout_oe),
   .o_coef_ptr(o_coef_ptr), .o_dec_factor(o_dec_factor),
   .o_dwn_freq(o_dwn_freq), .o_gain_comp(o_gain_comp),
   .o_coef_base(o_coef_base), .o_params_valid(o_params_valid));
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the profile and coefficient memories
// assumes the host model owns the serial pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rst_b, sync, adc_ok;
   logic [7:0] off;
   logic [63:0] va, vb;
   wire sn, sck, sd, ds, dq, oe, vld;
   wire [7:0] ptr, base;
   wire [5:0] dec;
   wire [15:0] frq;
   wire [2:0] gn;
   wire [111:0] blk;
   int err_total, num_checks;
   dpcr_spi_host i_host (.o_select_n(sn), .o_sclk(sck), .o_din(sd),
      .o_dsel(ds));
   dpcr_profile_coeff_ram i_dut (.i_sys_clk(clk), .i_rst_b(rst_b),
      .i_serial_select_n(sn), .i_serial_clk(sck), .i_serial_din(sd),
      .i_digital_space_select(ds), .o_serial_dout(dq),
      .o_serial_dout_oe(oe), .i_tx_sync(sync), .i_adc_clk_ok(adc_ok),
      .o_coef_ptr(ptr), .o_dec_factor(dec), .o_dwn_freq(frq),
      .o_gain_comp(gn), .o_coef_base(base), .o_params_valid(vld),
      .i_coef_rd_off(off), .o_coef_block(blk));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [63:0] vec(input logic [7:0] p,
         input logic [5:0] m, input logic [15:0] f, input logic [2:0] g);
      return {28'h0, p, m, f, 1'b0, g, 2'b11};
   endfunction
   // falling coefficients so the block holds negative values too
   function automatic logic [111:0] cf(input logic [13:0] c);
      logic [111:0] b;
      for (int k = 0; k < 8; k++) b[14*k +: 14] = c - 14'(k);
      return b;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [111:0] got, input logic [111:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic chk_prm(input logic [63:0] v, input logic on);
      chk({vld, ptr, dec, frq, gn, base},
         {on, v[35:22], v[21:6], v[4:2], v[32:28], 3'h0});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #300000;
      err_total++;
      $display("mismatch %0t: watchdog expired", $time);
      wrap_up;
   end
   initial begin
      rst_b = 1'b0;
      sync = 1'b0;
      adc_ok = 1'b1;
      off = 8'h00;
      va = vec(8'h02, 6'h03, 16'h1234, 3'h5);
      vb = vec(8'h25, 6'h20, 16'hfedc, 3'h7);
      wt(2);
      rst_b = 1'b1;
      wt(4);
      i_host.open_frame;
      i_host.send(8'hc8, 112'h5, 16);
      i_host.send(8'hc9, 112'(va), 64);
      i_host.send(8'hc9, 112'(vb), 64);
      i_host.send(8'hc6, 112'h10, 16);
      i_host.send(8'hc7, cf(14'h0002), 112);
      i_host.send(8'hc7, cf(14'h3ff0), 112);
      i_host.send(8'hce, 112'h3000, 16);
      i_host.close_frame;
      wt(12);
      chk_prm(64'h0, 1'b0);
      i_host.open_frame;
      i_host.send(8'hc0, 112'h4, 16);
      i_host.close_frame;
      wt(12);
      chk_prm(vb, 1'b1);
      i_host.open_frame;
      i_host.send(8'hce, 112'h2800, 16);
      i_host.close_frame;
      wt(3);
      sync = 1'b1;
      wt(5);
      sync = 1'b0;
      wt(8);
      chk_prm(va, 1'b1);
      chk(blk, cf(14'h0002));
      off = 8'h01;
      wt(3);
      chk(blk, cf(14'h3ff0));
      i_host.open_frame;
      i_host.send(8'hc8, 112'h5, 16);
      i_host.close_frame;
      wt(2);
      adc_ok = 1'b0;
      i_host.open_frame;
      i_host.send(8'hc9, 112'(vb), 64);
      i_host.close_frame;
      wt(2);
      adc_ok = 1'b1;
      i_host.open_frame;
      i_host.send(8'h4e, 112'h3000, 16);
      i_host.send(8'hc0, 112'h4, 16);
      i_host.close_frame;
      wt(12);
      chk_prm(va, 1'b1);
      i_host.open_frame;
      i_host.send(8'hdf, 112'h88c4, 16);
      i_host.send(8'he0, 112'h1, 16);
      i_host.send(8'he1, 112'habcd, 16);
      i_host.send(8'hdd, 112'hb0, 16);
      i_host.send(8'hc0, 112'h4, 16);
      i_host.close_frame;
      wt(12);
      chk_prm(vec(8'h11, 6'h04, 16'habcd, 3'h3), 1'b1);
      wrap_up;
   end
endmodule
`default_nettype wire
